// file: rtl/bfp_consts.vh
`ifndef BFP_CONSTS_VH
`define BFP_CONSTS_VH

// ----------------------------------------------------------------
// Clock rate
// ----------------------------------------------------------------
`define BFP_CLK_KHZ 50000

// ----------------------------------------------------------------
// Interval figures in their own units
// ----------------------------------------------------------------
`define BFP_T_BURST_BLANK_MS 20
`define BFP_T_OVLD_BLANK_MS 20
`define BFP_T_SPIKE_US 30
`define BFP_T_OVP_US 120
`define BFP_T_UV_MS 10
`define BFP_T_AE_BLANK_MS 1
`define BFP_T_SOFTSTART_MS 20

// ----------------------------------------------------------------
// Conversion to clock cycles
// ----------------------------------------------------------------
`define BFP_CYC_MS(t) ((t) * `BFP_CLK_KHZ)
`define BFP_CYC_US(t) ((t) * `BFP_CLK_KHZ / 1000)

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define BFP_CNT_W 24
`define BFP_SYNC_W 11
`define BFP_SYNC_RST 11'h000
`define BFP_ST_W 2

`endif

// file: rtl/bfp_ctrl.v
`timescale 1ns/1ns
`include "bfp_consts.vh"

// Summary of operation
// - Feedback below 1.35 V held for 20 ms moves normal operation into burst mode.
// - In burst with switching paused, feedback above 3.5 V restores bias and switching.
// - The reduced 0.34 V current limit is selected for the whole of burst mode.
// - In a burst pulse train, feedback falling to 3.0 V removes bias and switching.
// - Feedback above 4.0 V in burst leaves burst at once with the full current limit.
// - Overload goes through the extendable blanking; other faults restart directly.
// - In soft start, supply above 20.5 V with feedback above 4 V for 30 us restarts.
// - Outside burst, supply above 25.5 V for 120 us plus 30 us restarts.
// - Over-temperature held for 30 us restarts.
// - Feedback above 4.0 V outside burst for 20 ms releases the blanking clamp switch.
// - With the clamp released, blanking node high and feedback high for 30 us restarts.
// - Supply below the turn-off threshold for 10 ms plus 30 us restarts.
// - Blanking node below 0.33 V stops switching at once and restarts after 30 us.
// - The restart-enable pull-down is ignored for 1 ms after each start-up.
// - In restart, switching stops and the startup cell charges supply off to on.
// - Each restart runs soft start and then normal operation, faults still checked.
module bfp_ctrl #(
   parameter [`BFP_CNT_W-1:0] BURST_BLANK_CYC = `BFP_CYC_MS(`BFP_T_BURST_BLANK_MS),
   parameter [`BFP_CNT_W-1:0] OVLD_BLANK_CYC = `BFP_CYC_MS(`BFP_T_OVLD_BLANK_MS),
   parameter [`BFP_CNT_W-1:0] OVP_CYC = `BFP_CYC_US(`BFP_T_OVP_US + `BFP_T_SPIKE_US),
   parameter [`BFP_CNT_W-1:0] UV_CYC =
      `BFP_CYC_MS(`BFP_T_UV_MS) + `BFP_CYC_US(`BFP_T_SPIKE_US),
   parameter [`BFP_CNT_W-1:0] AE_BLANK_CYC = `BFP_CYC_MS(`BFP_T_AE_BLANK_MS),
   parameter [`BFP_CNT_W-1:0] SOFTSTART_CYC = `BFP_CYC_MS(`BFP_T_SOFTSTART_MS)
) (
   // Clock and reset
   input wire i_core_clk,
   input wire i_sys_rst,
   // Feedback comparators
   input wire i_fb_below_entry,
   input wire i_fb_above_burst_on,
   input wire i_fb_above_burst_off,
   input wire i_fb_high,
   // Supply comparators
   input wire i_vcc_above_ss_ovp,
   input wire i_vcc_above_ovp,
   input wire i_vcc_below_off,
   input wire i_vcc_above_on,
   // Temperature and blanking node
   input wire i_over_temp,
   input wire i_ba_above_high,
   input wire i_ba_below_restart,
   // Power stage control
   output reg o_switch_en_ff,
   output reg o_reduced_limit_ff,
   output reg o_bias_on_ff,
   output reg o_startup_cell_on_ff,
   output reg o_blanking_clamp_switch_ff,
   // Status
   output reg o_burst_flag_ff,
   output reg o_auto_restart_ff
);

   // ----------------------------------------------------------------
   // Local constants
   // ----------------------------------------------------------------
   localparam [`BFP_CNT_W-1:0] SPIKE_CYC = `BFP_CYC_US(`BFP_T_SPIKE_US);
   localparam [`BFP_ST_W-1:0] ST_SOFTSTART = 2'h0;
   localparam [`BFP_ST_W-1:0] ST_NORMAL = 2'h1;
   localparam [`BFP_ST_W-1:0] ST_BURST = 2'h2;
   localparam [`BFP_ST_W-1:0] ST_RESTART = 2'h3;

   // ----------------------------------------------------------------
   // Input synchroniser
   // ----------------------------------------------------------------
   wire [`BFP_SYNC_W-1:0] raw_in;
   reg [`BFP_SYNC_W-1:0] sync1_ff;
   reg [`BFP_SYNC_W-1:0] sync2_ff;

   assign raw_in = {i_fb_below_entry, i_fb_above_burst_on, i_fb_above_burst_off,
                    i_fb_high, i_vcc_above_ss_ovp, i_vcc_above_ovp, i_vcc_below_off,
                    i_vcc_above_on, i_over_temp, i_ba_above_high, i_ba_below_restart};

   // Two flip-flops per comparator level
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         sync1_ff <= `BFP_SYNC_RST;
         sync2_ff <= `BFP_SYNC_RST;
      end else begin
         sync1_ff <= raw_in;
         sync2_ff <= sync1_ff;
      end
   end

   // Named views of the synchronised levels
   wire fb_below_entry = sync2_ff[10];
   wire fb_above_on = sync2_ff[9];
   wire fb_above_off = sync2_ff[8];
   wire fb_high = sync2_ff[7];
   wire vcc_ss_ovp = sync2_ff[6];
   wire vcc_ovp = sync2_ff[5];
   wire vcc_below_off = sync2_ff[4];
   wire vcc_above_on = sync2_ff[3];
   wire over_temp = sync2_ff[2];
   wire ba_high = sync2_ff[1];
   wire ba_low = sync2_ff[0];

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   reg [`BFP_ST_W-1:0] state_ff;
   reg [`BFP_ST_W-1:0] nxt_state;
   reg burst_on_ff;
   reg nxt_burst_on;
   reg cell_on_ff;
   reg nxt_cell_on;

   wire in_restart = (state_ff == ST_RESTART);
   wire in_burst = (state_ff == ST_BURST);
   wire in_ss = (state_ff == ST_SOFTSTART);
   wire running = !in_restart && !in_burst;

   // ----------------------------------------------------------------
   // Persistence qualifiers
   // ----------------------------------------------------------------
   wire q_burst_entry;
   wire q_ovld_blank;
   wire q_ovld;
   wire q_ss_ovp;
   wire q_ovp;
   wire q_ot;
   wire q_uv;
   wire q_ae;
   wire ae_armed;
   wire ss_done;
   wire clamp_released;

   // Burst entry blanking
   bfp_qual #(.COUNT(BURST_BLANK_CYC)) u_q_burst (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_cond(state_ff == ST_NORMAL && fb_below_entry),
      .o_done_ff(q_burst_entry)
   );

   // Overload basic blanking; done releases the clamp switch
   bfp_qual #(.COUNT(OVLD_BLANK_CYC)) u_q_ovblank (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_cond(running && fb_high),
      .o_done_ff(q_ovld_blank)
   );
   assign clamp_released = q_ovld_blank;

   // Extended blanking end: node high and feedback high, spike blanked
   bfp_qual #(.COUNT(SPIKE_CYC)) u_q_ovld (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_cond(clamp_released && ba_high && fb_high),
      .o_done_ff(q_ovld)
   );

   // Supply overvoltage during soft start
   bfp_qual #(.COUNT(SPIKE_CYC)) u_q_ssovp (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_cond(in_ss && vcc_ss_ovp && fb_high),
      .o_done_ff(q_ss_ovp)
   );

   // Supply overvoltage, disabled in burst
   bfp_qual #(.COUNT(OVP_CYC)) u_q_ovp (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_cond(running && vcc_ovp),
      .o_done_ff(q_ovp)
   );

   // Over-temperature
   bfp_qual #(.COUNT(SPIKE_CYC)) u_q_ot (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_cond(!in_restart && over_temp),
      .o_done_ff(q_ot)
   );

   // Supply undervoltage or shorted optocoupler
   bfp_qual #(.COUNT(UV_CYC)) u_q_uv (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_cond(!in_restart && vcc_below_off),
      .o_done_ff(q_uv)
   );

   // Start-up window during which restart-enable is ignored
   bfp_qual #(.COUNT(AE_BLANK_CYC)) u_q_aeblank (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_cond(!in_restart),
      .o_done_ff(ae_armed)
   );

   // External restart enable once armed
   bfp_qual #(.COUNT(SPIKE_CYC)) u_q_ae (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_cond(ae_armed && ba_low),
      .o_done_ff(q_ae)
   );

   // Soft start duration
   bfp_qual #(.COUNT(SOFTSTART_CYC)) u_q_ss (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_cond(in_ss),
      .o_done_ff(ss_done)
   );

   // Any qualified fault; direct faults bypass the extended blanking
   wire fault = q_ovld | q_ss_ovp | q_ovp | q_ot | q_uv | q_ae;
   wire ae_stop = ae_armed && ba_low;

   // ----------------------------------------------------------------
   // Mode sequencing
   // ----------------------------------------------------------------
   always @* begin
      nxt_state = state_ff;
      nxt_burst_on = burst_on_ff;
      nxt_cell_on = cell_on_ff;
      case (state_ff)
         ST_SOFTSTART: begin
            if (fault) begin
               nxt_state = ST_RESTART;
            end else if (ss_done) begin
               nxt_state = ST_NORMAL;
            end
         end
         ST_NORMAL: begin
            if (fault) begin
               nxt_state = ST_RESTART;
            end else if (q_burst_entry) begin
               nxt_state = ST_BURST;
               nxt_burst_on = 1'b0;
            end
         end
         ST_BURST: begin
            if (fault) begin
               nxt_state = ST_RESTART;
               nxt_burst_on = 1'b0;
            end else if (fb_high) begin
               nxt_state = ST_NORMAL;
               nxt_burst_on = 1'b0;
            end else if (!burst_on_ff && fb_above_on) begin
               nxt_burst_on = 1'b1;
            end else if (burst_on_ff && !fb_above_off) begin
               nxt_burst_on = 1'b0;
            end
         end
         ST_RESTART: begin
            if (!cell_on_ff && vcc_below_off) begin
               nxt_cell_on = 1'b1;
            end else if (cell_on_ff && vcc_above_on) begin
               nxt_cell_on = 1'b0;
               nxt_state = ST_SOFTSTART;
            end
         end
         default: begin
            nxt_state = ST_SOFTSTART;
            nxt_burst_on = 1'b0;
            nxt_cell_on = 1'b0;
         end
      endcase
   end

   // State flip-flops
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         state_ff <= ST_SOFTSTART;
         burst_on_ff <= 1'b0;
         cell_on_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         burst_on_ff <= nxt_burst_on;
         cell_on_ff <= nxt_cell_on;
      end
   end

   // ----------------------------------------------------------------
   // Output decode from next state and clamp release
   // ----------------------------------------------------------------
   reg nxt_switch_en;
   reg nxt_bias_on;
   wire nxt_burst = (nxt_state == ST_BURST);
   wire nxt_restart = (nxt_state == ST_RESTART);

   // Switching and bias per mode; restart-enable pull-down gates drive at once
   always @* begin
      if (nxt_restart) begin
         nxt_switch_en = 1'b0;
         nxt_bias_on = 1'b0;
      end else if (nxt_burst) begin
         nxt_switch_en = nxt_burst_on && !ae_stop;
         nxt_bias_on = nxt_burst_on;
      end else begin
         nxt_switch_en = !ae_stop;
         nxt_bias_on = 1'b1;
      end
   end

   // Registered outputs
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_switch_en_ff <= 1'b0;
         o_reduced_limit_ff <= 1'b0;
         o_bias_on_ff <= 1'b0;
         o_startup_cell_on_ff <= 1'b0;
         o_blanking_clamp_switch_ff <= 1'b1;
         o_burst_flag_ff <= 1'b0;
         o_auto_restart_ff <= 1'b0;
      end else begin
         o_switch_en_ff <= nxt_switch_en;
         o_reduced_limit_ff <= nxt_burst;
         o_bias_on_ff <= nxt_bias_on;
         o_startup_cell_on_ff <= nxt_cell_on;
         o_blanking_clamp_switch_ff <= !clamp_released;
         o_burst_flag_ff <= nxt_burst;
         o_auto_restart_ff <= nxt_restart;
      end
   end

endmodule // bfp_ctrl

// file: rtl/bfp_qual.v
`timescale 1ns/1ns
`include "bfp_consts.vh"

// Persistence qualifier: o_done rises once i_cond has held for COUNT cycles
module bfp_qual #(
   parameter [`BFP_CNT_W-1:0] COUNT = 24'h0005dc
) (
   // Clock and reset
   input wire i_core_clk,
   input wire i_sys_rst,
   // Condition and result
   input wire i_cond,
   output reg o_done_ff
);

   reg [`BFP_CNT_W-1:0] cnt_ff;
   wire at_end = (cnt_ff == COUNT - 24'h000001);

   // ----------------------------------------------------------------
   // Counter clears whenever the condition drops
   // ----------------------------------------------------------------
   always @(posedge i_core_clk) begin
      if (i_sys_rst || !i_cond) begin
         cnt_ff <= 24'h000000;
         o_done_ff <= 1'b0;
      end else begin
         if (!at_end && !o_done_ff) begin
            cnt_ff <= cnt_ff + 24'h000001;
         end
         if (at_end) begin
            o_done_ff <= 1'b1;
         end
      end
   end

endmodule // bfp_qual

// file: test/bfp_ctrl_chk.sv
`timescale 1ns/1ns

// ------------------------------------------------------------
// Port-level checker of the controller
// ------------------------------------------------------------
module bfp_ctrl_chk #(
   parameter int BURST_BLANK_CYC = 40,
   parameter int OVLD_BLANK_CYC = 40
) (
   // Clock and reset
   input wire i_core_clk,
   input wire i_sys_rst,
   // Watched inputs
   input wire i_fb_below_entry,
   input wire i_fb_above_burst_on,
   input wire i_fb_above_burst_off,
   input wire i_fb_high,
   input wire i_vcc_below_off,
   input wire i_over_temp,
   // Watched outputs
   input wire o_switch_en_ff,
   input wire o_reduced_limit_ff,
   input wire o_bias_on_ff,
   input wire o_startup_cell_on_ff,
   input wire o_blanking_clamp_switch_ff,
   input wire o_burst_flag_ff,
   input wire o_auto_restart_ff
);
   int low_cnt_ff;
   int high_cnt_ff;
   int hot_cnt_ff;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   // Run lengths of raw comparator levels
   always @(posedge i_core_clk) begin
      low_cnt_ff <= (i_sys_rst || !i_fb_below_entry) ? 0 : low_cnt_ff + 1;
      high_cnt_ff <= (i_sys_rst || !i_fb_high) ? 0 : high_cnt_ff + 1;
      hot_cnt_ff <= (i_sys_rst || !i_over_temp || o_auto_restart_ff) ? 0 : hot_cnt_ff + 1;
   end
   a_burst_entry_time: assert property ($rose(o_burst_flag_ff) |->
      $past(low_cnt_ff, 2) >= BURST_BLANK_CYC - 2) else $error("burst entered too early");
   a_burst_resume: assert property (o_burst_flag_ff && $rose(i_fb_above_burst_on) |->
      ##[1:4] o_switch_en_ff && o_bias_on_ff) else $error("burst pulses did not resume");
   a_limit_is_burst: assert property (o_reduced_limit_ff == o_burst_flag_ff)
      else $error("current limit select differs from burst flag");
   a_limit_release: assert property ($fell(o_reduced_limit_ff) |->
      $past(i_fb_high, 3) || o_auto_restart_ff) else $error("full limit restored without cause");
   a_burst_pause: assert property (o_burst_flag_ff && $fell(i_fb_above_burst_off) |->
      ##[1:4] !o_bias_on_ff) else $error("bias stayed on below lower level");
   a_burst_exit: assert property (o_burst_flag_ff && $rose(i_fb_high) |->
      ##[1:4] !o_burst_flag_ff) else $error("burst not left on high feedback");
   a_ot_restart: assert property (hot_cnt_ff == 1510 |-> o_auto_restart_ff)
      else $error("over-temperature did not restart");
   a_clamp_release: assert property ($fell(o_blanking_clamp_switch_ff) |->
      $past(high_cnt_ff, 2) >= OVLD_BLANK_CYC - 2) else $error("clamp released too early");
   a_restart_no_switch: assert property (o_auto_restart_ff |-> !o_switch_en_ff)
      else $error("switching during restart");
   a_cell_charge: assert property ((o_auto_restart_ff && i_vcc_below_off) [*5] |->
      o_startup_cell_on_ff) else $error("startup cell not on at turn-off level");
endmodule // bfp_ctrl_chk

// file: test/bfp_plant.sv
`timescale 1ns/1ns

// ------------------------------------------------------------
// Analog comparators and power stage around the controller
// ------------------------------------------------------------
module bfp_plant (
   // Clock and levels set by the bench, in millivolts
   input wire i_core_clk,
   input int i_fb_mv,
   input int i_vcc_set,
   input int i_ba_set,
   input wire i_hot,
   input wire i_ae_pull,
   // Controller outputs
   input wire i_restart,
   input wire i_cell_on,
   input wire i_clamp,
   // Comparator results
   output wire o_fb_lo,
   output wire o_fb_on,
   output wire o_fb_off,
   output wire o_fb_hi,
   output wire o_v_ss,
   output wire o_v_ov,
   output wire o_v_off,
   output wire o_v_on,
   output wire o_ot,
   output wire o_ba_hi,
   output wire o_ba_lo
);
   int vcc_ff = 15000;
   int ba_mv;
   // Supply sags while restart stops switching, the startup cell charges it
   always @(posedge i_core_clk) begin
      vcc_ff <= i_cell_on ? vcc_ff + 500 : i_restart ? vcc_ff - 500 : i_vcc_set;
   end
   // Pull-down transistor wins over the clamp, the clamp over the capacitor
   assign ba_mv = i_ae_pull ? 200 : i_clamp ? 900 : i_ba_set;
   // Threshold comparators
   assign o_fb_lo = i_fb_mv < 1350;
   assign o_fb_on = i_fb_mv > 3500;
   assign o_fb_off = i_fb_mv > 3000;
   assign o_fb_hi = i_fb_mv > 4000;
   assign o_v_ss = vcc_ff > 20500;
   assign o_v_ov = vcc_ff > 25500;
   assign o_v_off = vcc_ff < 10500;
   assign o_v_on = vcc_ff >= 18000;
   assign o_ot = i_hot;
   assign o_ba_hi = ba_mv > 4000;
   assign o_ba_lo = ba_mv < 330;
endmodule // bfp_plant

// file: test/test_burst_and_fault_protection_ctrl.sv
`timescale 1ns/1ns

// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module test_burst_and_fault_protection_ctrl;
   logic core_clk = 0;
   logic sys_rst = 1;
   logic hot = 0, ae_pull = 0, seen = 0;
   int fb_mv = 2000, vcc_set = 15000, ba_set = 4500, len, bad_count = 0, checked = 0;
   int seed = 32'h7f106531;
   wire i_fb_below_entry, i_fb_above_burst_on, i_fb_above_burst_off, i_fb_high;
   wire i_vcc_above_ss_ovp, i_vcc_above_ovp, i_vcc_below_off, i_vcc_above_on;
   wire i_over_temp, i_ba_above_high, i_ba_below_restart;
   wire o_switch_en_ff, o_reduced_limit_ff, o_bias_on_ff, o_startup_cell_on_ff;
   wire o_blanking_clamp_switch_ff, o_burst_flag_ff, o_auto_restart_ff;
   always #10 core_clk = ~core_clk;
   // Controller with shortened intervals
   bfp_ctrl #(.BURST_BLANK_CYC(24'h000028), .OVLD_BLANK_CYC(24'h000028), .OVP_CYC(24'h00001e),
      .UV_CYC(24'h00003c), .AE_BLANK_CYC(24'h000014), .SOFTSTART_CYC(24'h000800)) uut (
      .i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_fb_below_entry, .i_fb_above_burst_on,
      .i_fb_above_burst_off, .i_fb_high, .i_vcc_above_ss_ovp, .i_vcc_above_ovp,
      .i_vcc_below_off, .i_vcc_above_on, .i_over_temp, .i_ba_above_high, .i_ba_below_restart,
      .o_switch_en_ff, .o_reduced_limit_ff, .o_bias_on_ff, .o_startup_cell_on_ff,
      .o_blanking_clamp_switch_ff, .o_burst_flag_ff, .o_auto_restart_ff);
   // Comparators and power stage
   bfp_plant plant (.i_core_clk(core_clk), .i_fb_mv(fb_mv), .i_vcc_set(vcc_set),
      .i_ba_set(ba_set), .i_hot(hot), .i_ae_pull(ae_pull), .i_restart(o_auto_restart_ff),
      .i_cell_on(o_startup_cell_on_ff), .i_clamp(o_blanking_clamp_switch_ff),
      .o_fb_lo(i_fb_below_entry), .o_fb_on(i_fb_above_burst_on),
      .o_fb_off(i_fb_above_burst_off), .o_fb_hi(i_fb_high), .o_v_ss(i_vcc_above_ss_ovp),
      .o_v_ov(i_vcc_above_ovp), .o_v_off(i_vcc_below_off), .o_v_on(i_vcc_above_on),
      .o_ot(i_over_temp), .o_ba_hi(i_ba_above_high), .o_ba_lo(i_ba_below_restart));
   // Advance n edges, then step just past the edge
   task cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task check(input logic got, input logic exp, input int id);
      checked++;
      if (got !== exp) begin
         $display("unexpected %0t: output mismatch at check %0d", $time, id);
         bad_count++;
      end
   endtask
   task summarize;
      if (bad_count == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Ride out one restart cycle and see the startup cell work
   task restart_cycle(input int id);
      seen = 0;
      for (int i = 0; i < 400 && o_auto_restart_ff; i++) begin
         seen |= o_startup_cell_on_ff;
         cyc(1);
      end
      if (o_auto_restart_ff) begin
         $display("unexpected %0t: restart never ended", $time);
         bad_count++;
         summarize;
      end else begin
         check(seen, 1, id);
         check(o_switch_en_ff, 1, id + 1);
      end
   endtask
   // Main sequence
   initial begin
      cyc(20);
      check(o_switch_en_ff, 0, 1);
      check(o_blanking_clamp_switch_ff, 1, 2);
      sys_rst = 0;
      cyc(60);
      check(o_switch_en_ff, 1, 3);
      // Soft-start overvoltage with high feedback; blanking node still charging
      vcc_set = 21000;
      fb_mv = 4500;
      ba_set = 3000;
      cyc(1520);
      check(o_auto_restart_ff, 1, 33);
      vcc_set = 15000;
      fb_mv = 2000;
      ba_set = 4500;
      restart_cycle(35);
      cyc(2060);
      fb_mv = 1000;
      cyc(30);
      fb_mv = 2000;
      cyc(20);
      check(o_burst_flag_ff, 0, 4);
      fb_mv = 1000;
      cyc(50);
      check(o_burst_flag_ff, 1, 5);
      check(o_reduced_limit_ff, 1, 6);
      fb_mv = 3600;
      cyc(5);
      check(o_switch_en_ff, 1, 7);
      fb_mv = 2900;
      cyc(5);
      check(o_bias_on_ff, 0, 8);
      fb_mv = 4100;
      cyc(5);
      check(o_reduced_limit_ff, 0, 9);
      fb_mv = 2000;
      vcc_set = 26000;
      cyc(20);
      vcc_set = 15000;
      cyc(10);
      check(o_auto_restart_ff, 0, 10);
      vcc_set = 26000;
      cyc(40);
      check(o_auto_restart_ff, 1, 11);
      vcc_set = 15000;
      restart_cycle(12);
      cyc(2060);
      len = 100 + {$random(seed)} % 1300;
      hot = 1;
      cyc(len);
      hot = 0;
      cyc(10);
      check(o_auto_restart_ff, 0, 14);
      hot = 1;
      cyc(1520);
      check(o_auto_restart_ff, 1, 15);
      hot = 0;
      restart_cycle(16);
      cyc(2060);
      // Overload with a slow blanking capacitor, supply above the soft-start level
      fb_mv = 4500;
      ba_set = 3000;
      vcc_set = 21000;
      cyc(30);
      check(o_blanking_clamp_switch_ff, 1, 18);
      cyc(20);
      check(o_blanking_clamp_switch_ff, 0, 19);
      cyc(1520);
      check(o_auto_restart_ff, 0, 34);
      ba_set = 4500;
      cyc(1520);
      check(o_auto_restart_ff, 1, 20);
      fb_mv = 2000;
      vcc_set = 15000;
      restart_cycle(21);
      cyc(2060);
      vcc_set = 9000;
      cyc(40);
      check(o_auto_restart_ff, 0, 23);
      cyc(40);
      check(o_auto_restart_ff, 1, 24);
      vcc_set = 15000;
      restart_cycle(25);
      cyc(2060);
      ae_pull = 1;
      cyc(5);
      check(o_switch_en_ff, 0, 27);
      cyc(1510);
      check(o_auto_restart_ff, 1, 28);
      restart_cycle(29);
      cyc(5);
      check(o_switch_en_ff, 1, 31);
      cyc(25);
      check(o_switch_en_ff, 0, 32);
      ae_pull = 0;
      summarize;
   end
endmodule // test_burst_and_fault_protection_ctrl

bind bfp_ctrl bfp_ctrl_chk #(.BURST_BLANK_CYC(BURST_BLANK_CYC),
   .OVLD_BLANK_CYC(OVLD_BLANK_CYC)) chk (.i_core_clk, .i_sys_rst, .i_fb_below_entry,
   .i_fb_above_burst_on, .i_fb_above_burst_off, .i_fb_high, .i_vcc_below_off, .i_over_temp,
   .o_switch_en_ff, .o_reduced_limit_ff, .o_bias_on_ff, .o_startup_cell_on_ff,
   .o_blanking_clamp_switch_ff, .o_burst_flag_ff, .o_auto_restart_ff);
